// [hdl/rsf_core.sv]
// rate sensor frame decode, response build and fault latching
`timescale 1ns/1ps
`default_nettype none
module rsf_core
    import rsf_pkg::*;
#(
    parameter int INJ_CYCLES = INJ_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic [15:0] i_rate,
    input wire logic [15:0] i_quad_total,
    input wire logic i_quad_accum_limit,
    input wire logic i_pll_fault,
    input wire logic i_amp_fault,
    input wire logic i_ov_fault,
    input wire logic i_uv_fault,
    input wire logic [15:0] i_st_dev,
    input wire logic [15:0] i_nvm_sum,
    input wire logic [15:0] i_nvm_ref,
    input wire logic [7:0] i_por_copy,
    input wire logic [7:0] i_por_rom,
    output logic o_fault_inject,
    output logic [15:0] o_user_word
);
    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic tog_meta;
        logic tog_sync;
        logic exp_tog;
        logic [2:0] gap;
        logic du;
        logic chk;
        logic [21:0] inj;
        logic inj_on;
        logic [15:0] rate_snap;
        logic [15:0] user;
        logic [NFAULT-1:0] fl;
        logic [31:0] resp;
    } rsf_core_t;
    rsf_core_t st_ff, nxt_st;

    logic [31:0] cmd;
    logic [5:0] bits;
    logic seen_tog;
    logic nvm_bad;
    logic por_bad;
    logic [NFAULT-1:0] cond;
    logic [NFAULT-1:0] clr;
    logic gross;
    logic frame_end;
    logic frame_start;
    logic frame_bad;
    logic is_sensor;
    logic is_read;
    logic is_write;
    logic [8:0] addr;
    logic addr_ok;
    logic [2:0] seq;
    logic [7:0] primary_fault_register;
    logic [7:0] secondary_fault_register;
    logic [6:0] sens_faults;
    logic [15:0] rd_data;
    logic [31:0] r;

    rsf_link u_link (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_rst(i_rst),
        .i_mosi(i_mosi),
        .i_resp(st_ff.resp),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .o_cmd(cmd),
        .o_bits(bits),
        .o_seen_tog(seen_tog)
    );

    rsf_periodic_check #(
        .WIDTH(16),
        .PERIOD(NVM_CHECK_CYC)
    ) u_nvm_check (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_copy(i_nvm_sum),
        .i_ref(i_nvm_ref),
        .o_mismatch(nvm_bad)
    );

    rsf_periodic_check #(
        .WIDTH(8),
        .PERIOD(POR_CHECK_CYC)
    ) u_por_check (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_copy(i_por_copy),
        .i_ref(i_por_rom),
        .o_mismatch(por_bad)
    );

    function automatic logic [7:0] reg_byte(input logic [8:0] a,
            input rsf_core_t s, input logic [7:0] f0,
            input logic [7:0] f1);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            REG_RATE_HI: v = s.rate_snap[15:8];
            REG_RATE_LO: v = s.rate_snap[7:0];
            REG_QUAD_HI: v = i_quad_total[15:8];
            REG_QUAD_LO: v = i_quad_total[7:0];
            REG_SECONDARY_FAULT_REGISTER: v = f1;
            REG_PRIMARY_FAULT_REGISTER: v = f0;
            REG_USER_HI: v = s.user[15:8];
            REG_USER_LO: v = s.user[7:0];
            REG_PID_HI: v = PID_VALUE[15:8];
            REG_PID_LO: v = PID_VALUE[7:0];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // frame bounds seen through the synchronised select
    assign frame_end = st_ff.cs_sync & ~st_ff.cs_prev;
    assign frame_start = ~st_ff.cs_sync & st_ff.cs_prev;
    // wrong count, even parity, or no clock at all in the frame
    assign frame_bad = (bits != FRAME_BITS) || !(^cmd) ||
        (st_ff.tog_sync == st_ff.exp_tog);
    assign is_sensor = cmd[29];
    assign is_read = (cmd[31:29] == 3'h4);
    assign is_write = (cmd[31:29] == 3'h2);
    assign addr = cmd[25:17];
    assign seq = {cmd[28], cmd[31:30]};
    assign addr_ok = (addr <= REG_PID_LO) &&
        !(addr > REG_RATE_LO && addr < REG_QUAD_HI);

    // fault conditions; injection drives every one except fail
    assign gross = i_pll_fault || (i_st_dev > ST_GROSS_LSB);
    always_comb begin
        cond = '0;
        cond[F_PLL] = i_pll_fault;
        cond[F_QUAD] = (i_quad_total > QUAD_LIMIT) ||
            i_quad_accum_limit;
        cond[F_NVM] = nvm_bad;
        cond[F_POR] = por_bad;
        cond[F_PWR] = i_ov_fault || i_uv_fault;
        cond[F_CST] = (i_st_dev > ST_WARN_LSB);
        cond[F_CHK] = st_ff.chk;
        cond[F_AMP] = i_amp_fault;
        cond[F_OV] = i_ov_fault;
        cond[F_UV] = i_uv_fault;
        if (st_ff.inj != 22'h000000) begin
            cond = cond | (ALL_MASK & ~(11'h001 << F_FAIL));
        end
        cond[F_FAIL] = gross;
    end

    assign primary_fault_register = {st_ff.fl[F_PLL], st_ff.fl[F_QUAD], st_ff.fl[F_NVM],
        st_ff.fl[F_POR], st_ff.fl[F_PWR], st_ff.fl[F_CST],
        st_ff.fl[F_CHK], 1'b0};
    assign secondary_fault_register = {4'h0, st_ff.fl[F_FAIL], st_ff.fl[F_AMP],
        st_ff.fl[F_OV], st_ff.fl[F_UV]};
    // amplitude loss shares the self-test slot in sensor data
    assign sens_faults = {primary_fault_register[7:3],
        st_ff.fl[F_CST] | st_ff.fl[F_AMP], primary_fault_register[1]};
    assign rd_data = {reg_byte(addr, st_ff, primary_fault_register, secondary_fault_register),
        reg_byte(addr + 9'h001, st_ff, primary_fault_register, secondary_fault_register)};

    always_comb begin
        nxt_st = st_ff;
        clr = '0;
        r = st_ff.resp;
        nxt_st.cs_meta = i_cs_n;
        nxt_st.cs_sync = st_ff.cs_meta;
        nxt_st.cs_prev = st_ff.cs_sync;
        nxt_st.tog_meta = seen_tog;
        nxt_st.tog_sync = st_ff.tog_meta;
        if (st_ff.cs_sync && st_ff.gap != 3'h7) begin
            nxt_st.gap = st_ff.gap + 3'h1;
        end
        // rate is frozen when the frame opens
        if (frame_start) begin
            nxt_st.rate_snap = i_rate;
            if (st_ff.gap < 3'(GAP_MIN_CYC)) begin
                nxt_st.du = 1'b1;
            end
        end
        if (st_ff.chk) begin
            nxt_st.inj = 22'(INJ_CYCLES);
        end else if (st_ff.inj != 22'h000000) begin
            nxt_st.inj = st_ff.inj - 22'h000001;
        end
        // registered so the pin comes straight off a flop
        nxt_st.inj_on = (nxt_st.inj != 22'h000000);
        if (frame_end) begin
            nxt_st.gap = 3'h0;
            nxt_st.exp_tog = st_ff.tog_sync;
            // built now, shifted out during the next frame
            if (frame_bad || st_ff.du) begin
                r = {HDR_ERROR, 1'b0, RW_MARK, 3'h0, 2'h0, frame_bad,
                    1'b0, st_ff.du, 8'h00, primary_fault_register[7:1], 1'b0};
                nxt_st.du = 1'b0;
            end else if (is_sensor) begin
                nxt_st.chk = cmd[1];
                r = {seq, 1'b0, KIND_VALID, st_ff.rate_snap, 2'h0,
                    sens_faults, 1'b0};
                if (gross) begin
                    r[27:26] = KIND_ERROR;
                end else if (cmd[1] || st_ff.chk) begin
                    r[27:26] = KIND_SELFTEST;
                end
                clr = PRIMARY_MASK;
            end else if (is_read && addr_ok) begin
                r = {HDR_READ, 1'b0, RW_MARK, 3'h0, rd_data,
                    5'h00};
                if (addr == REG_SECONDARY_FAULT_REGISTER || addr == REG_PRIMARY_FAULT_REGISTER) begin
                    clr = ALL_MASK;
                end
            end else if (is_write && addr == REG_USER_HI) begin
                nxt_st.user = cmd[16:1];
                r = {HDR_WRITE, 1'b0, RW_MARK, 3'h0, cmd[16:1],
                    5'h00};
            end else begin
                r = {HDR_ERROR, 1'b0, RW_MARK, 3'h0, 2'h0, 1'b0, 1'b1,
                    1'b0, 8'h00, primary_fault_register[7:1], 1'b0};
            end
            r[28] = ~(^r[31:29] ^ ^r[27:16]);
            r[0] = ~^r[31:1];
            nxt_st.resp = r;
        end
        // a fault present during its read sets again at once
        nxt_st.fl = cond | (st_ff.fl & ~clr);
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
            st_ff.cs_meta <= 1'b1;
            st_ff.cs_sync <= 1'b1;
            st_ff.cs_prev <= 1'b1;
            st_ff.gap <= 3'h7;
            st_ff.user <= USER_RESET;
            st_ff.resp <= RESP_INIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_fault_inject = st_ff.inj_on;
    assign o_user_word = st_ff.user;

    a_seq_echo: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        frame_end && !frame_bad && !st_ff.du && is_sensor
        |=> st_ff.resp[31:29] == $past(seq))
        else $error("sequence tag not echoed");
    a_module_zero: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        st_ff.resp[27:26] == KIND_RW |-> st_ff.resp[23:21] == 3'h0)
        else $error("module select bits not zero");
    a_resp_parity: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        st_ff.resp != RESP_INIT
        |-> (^st_ff.resp[31:16]) && (^st_ff.resp))
        else $error("response parity not odd");
    a_frame_error: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        frame_end && frame_bad
        |=> st_ff.resp[31:29] == HDR_ERROR && st_ff.resp[18])
        else $error("bad frame not answered as error");
    a_gross_kind: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        frame_end && !frame_bad && !st_ff.du && is_sensor && gross
        |=> st_ff.resp[27:26] == KIND_ERROR ##1 st_ff.fl[F_FAIL])
        else $error("gross failure not flagged");
    a_supply_fault: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (i_ov_fault || i_uv_fault) |=> st_ff.fl[F_PWR])
        else $error("supply fault not latched");
    a_write_echo: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        frame_end && !frame_bad && !st_ff.du && is_write &&
        addr == REG_USER_HI
        |=> st_ff.resp[20:5] == $past(cmd[16:1]) &&
        o_user_word == $past(cmd[16:1]))
        else $error("write value not echoed");
    a_fault_hold: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        st_ff.fl[F_QUAD] && !frame_end |=> st_ff.fl[F_QUAD])
        else $error("latched fault dropped without a read");
    a_inject_all: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        st_ff.chk ##1 st_ff.chk |=> st_ff.fl[F_NVM] && st_ff.fl[F_POR]
        && st_ff.fl[F_CST])
        else $error("check bit did not induce faults");
    // a short deselect must show in the next answer and then drop
    a_data_unavail: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        frame_end && st_ff.du |=> st_ff.resp[16] && !st_ff.du)
        else $error("short gap not reported");
    a_quad_fault: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (i_quad_total > QUAD_LIMIT) |=> st_ff.fl[F_QUAD])
        else $error("quadrature fault not latched");
    a_nvm_fault: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        nvm_bad |=> st_ff.fl[F_NVM])
        else $error("checksum fault not latched");
    a_por_fault: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        por_bad |=> st_ff.fl[F_POR])
        else $error("reference copy fault not latched");
    a_selftest_kind: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        frame_end && !frame_bad && !st_ff.du && is_sensor && !gross &&
        st_ff.chk |=> st_ff.resp[27:26] == KIND_SELFTEST)
        else $error("check bit not reported as self-test");
endmodule
`default_nettype wire

// [hdl/rsf_pkg.sv]
// constants shared by the rate sensor frame and fault logic
package rsf_pkg;
    localparam int CORE_CLK_NS = 25;
    localparam int NVM_CHECK_US = 50;
    localparam int NVM_CHECK_CYC = NVM_CHECK_US * 1000 / CORE_CLK_NS;
    localparam int POR_CHECK_US = 1;
    localparam int POR_CHECK_CYC = POR_CHECK_US * 1000 / CORE_CLK_NS;
    localparam int INJ_TIME_MS = 50;
    localparam int INJ_CYC = INJ_TIME_MS * 1000000 / CORE_CLK_NS;
    localparam int GAP_MIN_PS = 100000;
    localparam int GAP_MIN_CYC = (GAP_MIN_PS + CORE_CLK_NS * 1000 - 1)
        / (CORE_CLK_NS * 1000);
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [31:0] RESP_INIT = 32'h00000001;
    localparam logic [15:0] QUAD_LIMIT = 16'h1000;
    localparam logic [15:0] ST_WARN_LSB = 16'h0140;
    localparam logic [15:0] ST_GROSS_LSB = 16'h0500;
    // register offsets
    localparam logic [8:0] REG_RATE_HI = 9'h000;
    localparam logic [8:0] REG_RATE_LO = 9'h001;
    localparam logic [8:0] REG_QUAD_HI = 9'h008;
    localparam logic [8:0] REG_QUAD_LO = 9'h009;
    localparam logic [8:0] REG_SECONDARY_FAULT_REGISTER = 9'h00A;
    localparam logic [8:0] REG_PRIMARY_FAULT_REGISTER = 9'h00B;
    localparam logic [8:0] REG_USER_HI = 9'h00C;
    localparam logic [8:0] REG_USER_LO = 9'h00D;
    localparam logic [8:0] REG_PID_HI = 9'h00E;
    localparam logic [8:0] REG_PID_LO = 9'h00F;
    localparam logic [15:0] USER_RESET = 16'h0000;
    // arbitrary product identification value
    localparam logic [15:0] PID_VALUE = 16'h5A01;
    // response kind codes
    localparam logic [1:0] KIND_ERROR = 2'h0;
    localparam logic [1:0] KIND_VALID = 2'h1;
    localparam logic [1:0] KIND_SELFTEST = 2'h2;
    localparam logic [1:0] KIND_RW = 2'h3;
    // fixed response headers, bits 31:29, and read/write mark, bits 27:24
    localparam logic [2:0] HDR_READ = 3'h2;
    localparam logic [2:0] HDR_WRITE = 3'h1;
    localparam logic [2:0] HDR_ERROR = 3'h0;
    localparam logic [3:0] RW_MARK = 4'hE;
    // fault latch indices
    localparam int F_PLL = 0;
    localparam int F_QUAD = 1;
    localparam int F_NVM = 2;
    localparam int F_POR = 3;
    localparam int F_PWR = 4;
    localparam int F_CST = 5;
    localparam int F_CHK = 6;
    localparam int F_AMP = 7;
    localparam int F_OV = 8;
    localparam int F_UV = 9;
    localparam int F_FAIL = 10;
    localparam int NFAULT = 11;
    localparam logic [10:0] PRIMARY_MASK = 11'h07F;
    localparam logic [10:0] ALL_MASK = 11'h7FF;
endpackage

// [hdl/rsf_periodic_check.sv]
// periodic compare of a working copy against its reference
`timescale 1ns/1ps
`default_nettype none
module rsf_periodic_check #(
    parameter int WIDTH = 16,
    parameter int PERIOD = 40
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_copy,
    input wire logic [WIDTH-1:0] i_ref,
    output logic o_mismatch
);
    typedef struct packed {
        logic [15:0] cnt;
        logic bad;
    } rsf_chk_t;
    rsf_chk_t st_ff, nxt_st;
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt == 16'(PERIOD - 1)) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.bad = (i_copy != i_ref);
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign o_mismatch = st_ff.bad;
endmodule
`default_nettype wire

// [hdl/rsf_link.sv]
// serial link shifter on the host's clock, mode 0
`timescale 1ns/1ps
`default_nettype none
module rsf_link
    import rsf_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_rst,
    input wire logic i_mosi,
    input wire logic [31:0] i_resp,
    output logic o_miso,
    output logic o_miso_oe,
    output logic [31:0] o_cmd,
    output logic [5:0] o_bits,
    output logic o_seen_tog
);
    logic frame_tog_ff;
    logic seen_tog_ff;
    logic [5:0] bits_ff;
    logic [31:0] cmd_ff;
    logic miso_ff;
    logic first;
    // sclk stops between frames, so a new frame is told by a toggle
    always_ff @(negedge i_cs_n or posedge i_rst) begin
        if (i_rst) begin
            frame_tog_ff <= 1'b0;
        end else begin
            frame_tog_ff <= ~frame_tog_ff;
        end
    end
    assign first = (seen_tog_ff != frame_tog_ff);
    // sample on rising edge, count saturates to flag long frames
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            seen_tog_ff <= 1'b0;
            bits_ff <= 6'h00;
            cmd_ff <= 32'h00000000;
        end else if (first) begin
            seen_tog_ff <= frame_tog_ff;
            bits_ff <= 6'h01;
            cmd_ff <= {31'h00000000, i_mosi};
        end else begin
            if (bits_ff != 6'h3F) begin
                bits_ff <= bits_ff + 6'h01;
            end
            cmd_ff <= {cmd_ff[30:0], i_mosi};
        end
    end
    // next bit changes on falling edge; msb stands before first edge
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            miso_ff <= 1'b0;
        end else if (bits_ff < FRAME_BITS) begin
            miso_ff <= i_resp[5'(6'h1F - bits_ff)];
        end else begin
            miso_ff <= 1'b0;
        end
    end
    assign o_miso = first ? i_resp[31] : miso_ff;
    assign o_miso_oe = ~i_cs_n;
    assign o_cmd = cmd_ff;
    assign o_bits = bits_ff;
    assign o_seen_tog = seen_tog_ff;
endmodule
`default_nettype wire

// [verif/rsf_host.sv]
// host model: serial bus master driving mode 0 frames
`timescale 1ns/1ps
`default_nettype none
module rsf_host (
    output var logic o_sclk,
    output var logic o_cs_n,
    output var logic o_mosi,
    input wire logic i_miso
);
    localparam int HALF = 40;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // n other than 32 breaks framing on purpose
    task automatic xfer(input logic [31:0] c, input int n, input int gap,
            output logic [31:0] r);
        r = 32'h0;
        // non-blocking so select never races the core's sampling edge
        o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_mosi <= c[31 - (i % 32)];
            #HALF;
            o_sclk <= 1'b1;
            r = {r[30:0], i_miso};
            #HALF;
            o_sclk <= 1'b0;
        end
        #HALF;
        o_cs_n <= 1'b1;
        // released line must not keep showing the last bit
        o_mosi <= ~o_mosi;
        #gap;
    endtask
endmodule
`default_nettype wire

// [verif/rsf_core_bench.sv]
// self-checking bench for the rate sensor frame and fault core
`timescale 1ns/1ps
`default_nettype none
module rsf_core_bench
    import rsf_pkg::*;
;
    logic clk, rst, sclk, cs_n, mosi, miso, accum, pll, resonator_amplitude_fault, ov, uv, inj;
    logic [15:0] rate, quad, st_dev, nvm_sum, nvm_ref, user;
    logic [7:0] por_copy, por_rom;
    logic oe;
    logic [31:0] rr, ex;
    int bad_count = 0;
    int n_tests = 0;
    logic [6:0] fx [10] = '{7'h40, 7'h20, 7'h00, 7'h20, 7'h10, 7'h08,
        7'h04, 7'h02, 7'h02, 7'h02};

    rsf_core #(.INJ_CYCLES(20)) uut (
        .i_core_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .i_rate(rate),
        .i_quad_total(quad), .i_quad_accum_limit(accum),
        .i_pll_fault(pll), .i_amp_fault(resonator_amplitude_fault), .i_ov_fault(ov),
        .i_uv_fault(uv), .i_st_dev(st_dev), .i_nvm_sum(nvm_sum),
        .i_nvm_ref(nvm_ref), .i_por_copy(por_copy), .i_por_rom(por_rom),
        .o_fault_inject(inj), .o_user_word(user)
    );
    rsf_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] cp(input logic [31:0] c);
        c[0] = ~^c[31:1];
        return c;
    endfunction
    function automatic logic [31:0] rp(input logic [31:0] r);
        r[28] = ~^{r[31:29], r[27:16]};
        r[0] = ~^r[31:1];
        return r;
    endfunction
    // junk in the address field must be ignored
    function automatic logic [31:0] sens(input logic [2:0] q, input logic k);
        return cp({q[1:0], 1'b1, q[2], 2'b00, 9'h1A5, 15'h0, k, 1'b0});
    endfunction
    function automatic logic [31:0] rd(input logic [8:0] a);
        return cp({6'h20, a, 17'h0});
    endfunction
    function automatic logic [31:0] wr(input logic [8:0] a,
            input logic [15:0] d);
        return cp({6'h10, a, d, 1'b0});
    endfunction
    function automatic logic [31:0] es(input logic [2:0] q,
            input logic [1:0] k, input logic [15:0] r, input logic [6:0] f);
        return rp({q, 1'b0, k, r, 2'b00, f, 1'b0});
    endfunction
    function automatic logic [31:0] erw(input logic [2:0] h,
            input logic [15:0] d);
        return rp({h, 1'b0, RW_MARK, 3'h0, d, 5'h0});
    endfunction
    function automatic logic [31:0] eer(input logic [2:0] b);
        return rp({4'h0, RW_MARK, 5'h0, b, 8'h0, 7'h0, 1'b0});
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic fr(input logic [31:0] c);
        host.xfer(c, 32, 250, rr);
    endtask
    task automatic wc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic setc(input int i, input logic on);
        logic [9:0] s;
        s = on ? 10'(1 << i) : 10'h0;
        @(posedge clk);
        pll <= s[0];
        quad <= s[1] ? 16'h1001 : s[2] ? QUAD_LIMIT : 16'h0100;
        accum <= s[3];
        nvm_ref <= s[4] ? 16'h0000 : 16'hBEEF;
        por_rom <= s[5] ? 8'h00 : 8'h5A;
        uv <= s[6];
        resonator_amplitude_fault <= s[7];
        st_dev <= s[8] ? 16'h0141 : s[9] ? 16'h0501 : 16'h0000;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // about 50k core cycles of traffic expected
    initial begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        {accum, pll, resonator_amplitude_fault, ov, uv} = 5'h00;
        rate = 16'h0F00;
        quad = 16'h0100;
        st_dev = 16'h0000;
        nvm_sum = 16'hBEEF;
        nvm_ref = 16'hBEEF;
        por_copy = 8'h5A;
        por_rom = 8'h5A;
        wc(12);
        rst <= 1'b0;
        wc(4);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            rate <= 16'h0F00 + 16'(k);
            fr(sens(3'(k), 1'b0));
            ex = es(3'(k - 1), KIND_VALID, rate - 16'h0001, 7'h0);
            if (k == 0) begin
                chk("first reply", rr, RESP_INIT);
            end else begin
                chk("sensor reply", rr, ex);
            end
        end
        $display("test sensor done");
        fork
            fr(wr(REG_USER_HI, 16'hA55A));
            begin
                wc(20);
                chk("miso drive", 32'(oe), 32'h1);
            end
        join
        chk("miso idle", 32'(oe), 32'h0);
        chk("last sensor", rr, es(3'h7, KIND_VALID, rate, 7'h0));
        chk("user word", 32'(user), 32'hA55A);
        fr(rd(REG_USER_HI));
        chk("write echo", rr, erw(HDR_WRITE, 16'hA55A));
        fr(rd(REG_QUAD_HI));
        chk("user read", rr, erw(HDR_READ, 16'hA55A));
        fr(rd(REG_PID_HI));
        chk("quad read", rr, erw(HDR_READ, 16'h0100));
        fr(wr(REG_QUAD_HI, 16'h1111));
        chk("id read", rr, erw(HDR_READ, PID_VALUE));
        fr(rd(9'h003));
        chk("ro write", rr, eer(3'b010));
        fr(cp(32'hC0000000));
        chk("bad register", rr, eer(3'b010));
        fr(sens(3'h1, 1'b0) ^ 32'h1);
        chk("bad command", rr, eer(3'b010));
        host.xfer(sens(3'h2, 1'b0), 31, 250, rr);
        chk("parity error", rr, eer(3'b100) >> 1);
        fr(sens(3'h3, 1'b0));
        chk("short frame", rr, eer(3'b100));
        fr(sens(3'h4, 1'b0));
        chk("recovered", rr, es(3'h3, KIND_VALID, rate, 7'h0));
        $display("test registers done");
        host.xfer(sens(3'h5, 1'b0), 32, 50, rr);
        fr(sens(3'h6, 1'b0));
        fr(sens(3'h7, 1'b0));
        chk("short gap", rr, eer(3'b001));
        $display("test gap done");
        // nvm compare period is 2000 cycles, so wait past it
        for (int i = 0; i < 10; i++) begin
            setc(i, 1'b1);
            wc(2100);
            fr(sens(3'h1, 1'b0));
            setc(i, 1'b0);
            wc(2100);
            fr(sens(3'h2, 1'b0));
            ex = es(3'h1, (i == 0 || i == 9) ? KIND_ERROR : KIND_VALID, rate,
                fx[i]);
            chk("fault reply", rr, ex);
            fr(sens(3'h3, 1'b0));
            chk("latched", rr, es(3'h2, KIND_VALID, rate, fx[i]));
            // amplitude latch sits in the second register until read
            ex = es(3'h3, KIND_VALID, rate, (i == 7) ? 7'h02 : 7'h00);
            fr(rd(REG_SECONDARY_FAULT_REGISTER));
            chk("cleared", rr, ex);
        end
        $display("test faults done");
        @(posedge clk);
        pll <= 1'b1;
        ov <= 1'b1;
        wc(100);
        fr(rd(REG_SECONDARY_FAULT_REGISTER));
        fr(sens(3'h0, 1'b0));
        chk("fault regs", rr, erw(HDR_READ, 16'h0A88));
        fr(sens(3'h1, 1'b0));
        chk("power", rr, es(3'h0, KIND_ERROR, rate, 7'h44));
        @(posedge clk);
        pll <= 1'b0;
        ov <= 1'b0;
        $display("test fault registers done");
        fr(sens(3'h1, 1'b1));
        chk("inject on", 32'(inj), 32'h1);
        fr(sens(3'h2, 1'b0));
        fr(sens(3'h3, 1'b0));
        chk("selftest", rr, es(3'h2, KIND_SELFTEST, rate, 7'h7F));
        wc(100);
        chk("inject off", 32'(inj), 32'h0);
        fr(sens(3'h4, 1'b0));
        chk("decay", rr, es(3'h3, KIND_VALID, rate, 7'h7F));
        fr(sens(3'h5, 1'b0));
        // injected amplitude latch still shows until a register read
        chk("clean", rr, es(3'h4, KIND_VALID, rate, 7'h02));
        $display("test inject done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
